// *** mrs_defs.svh ***
/*
 Constants of the serial-bus slave: frame layout, function and exception
 codes, page map, control word bits and timing in character times.
 Assumes a byte-level receiver and transmitter outside the block.
*/
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH

`define MRS_CRC_POLY     16'ha001
`define MRS_CRC_INIT     16'hffff
`define MRS_SIL_CHARS    2'h3
`define MRS_BUF_BYTES    5'h10
`define MRS_ADDR_BCAST   8'h00
`define MRS_ADDR_MAX     8'hf7
`define MRS_FC_RD_HOLD   8'h03
`define MRS_FC_RD_INPUT  8'h04
`define MRS_FC_WR_BIT    8'h05
`define MRS_FC_WR_WORD   8'h06
`define MRS_FC_QUICK     8'h07
`define MRS_FC_WR_MULTI  8'h10
`define MRS_FC_EXC_BIT   8'h80
`define MRS_EXC_FUNC     8'h01
`define MRS_EXC_DATA     8'h03
`define MRS_LEN_FIXED    5'h08
`define MRS_LEN_QUICK    5'h04
`define MRS_LEN_MULTI0   5'h09
`define MRS_RD_MAX       16'h007d
`define MRS_WR_MAX       16'h0002
`define MRS_COIL_ON      16'hff00
`define MRS_COIL_OFF     16'h0000
`define MRS_QUICK_ADDR   16'h0700
`define MRS_CTRL_ADDR    16'h0400
`define MRS_CTRL_MANUAL  12
`define MRS_CTRL_ACK_EVT 13
`define MRS_CTRL_ACK_FLT 14
`define MRS_PG_INFO      8'h00
`define MRS_PG_PAR_LAST  8'h04
`define MRS_PG_TSYNC     8'h08
`define MRS_PG_DIST_LO   8'h09
`define MRS_PG_DIST_HI   8'h21
`define MRS_PG_DIST_IDX  8'h22
`define MRS_OFS_DIST_MAX 8'hfa
`define MRS_PG_EVT       8'h35
`define MRS_OFS_EVT_MAX  8'h63
`define MRS_PG_EVT_OLD   8'h36
`define MRS_PG_FLT       8'h37
`define MRS_OFS_FLT_MAX  8'h04
`define MRS_PG_SEL_LO    8'h38
`define MRS_PG_SEL_HI    8'h3c
`define MRS_PG_FLT_OLD   8'h3e

`endif

// *** mrs_pkg.sv ***
/*
 Types of the serial-bus slave.
 Assumes mrs_defs.svh supplies the numeric constants.
*/
package mrs_pkg;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_EVAL = 4'b0001,
        S_WR   = 4'b0010,
        S_RD   = 4'b0011,
        S_RDW  = 4'b0100,
        S_CAP  = 4'b0101,
        S_TX   = 4'b0110,
        S_TXW  = 4'b0111,
        S_DONE = 4'b1000
    } mrs_state_t;

    typedef enum logic [1:0] {
        PH_BODY = 2'b00,
        PH_CRCL = 2'b01,
        PH_CRCH = 2'b10
    } mrs_phase_t;

endpackage

// *** mrs_crc16.sv ***
/*
 Byte-wise CRC16 accumulator, reflected form.
 Assumes the caller pulses en once per byte; start restarts the sum.
*/
`timescale 1ns/1ps
`include "mrs_defs.svh"

module mrs_crc16 #(
    parameter logic [15:0] POLY = `MRS_CRC_POLY
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        en,
    input  wire logic        start,
    input  wire logic [7:0]  din,
    output logic      [15:0] crc_r
);

    function automatic logic [15:0] upd(input logic [15:0] c_in,
                                        input logic [7:0]  d);
        logic [15:0] c;
        c = c_in ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ POLY) : (c >> 1);
        end
        return c;
    endfunction

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            crc_r <= `MRS_CRC_INIT;
        else if (en)
            crc_r <= upd(start ? `MRS_CRC_INIT : crc_r, din);
    end

endmodule

// *** mrs_slave.sv ***
/*
 Query interpreter of the serial-bus slave: frame gathering, address and
 CRC check, page access control, replies and record acknowledgement.
 Assumes a byte receiver (rx_valid pulses), a byte sender that takes
 tx_data when tx_valid and tx_ready are both high, char_tick once per
 character time, and a word store that answers a read one cycle after
 mem_rd is seen high.
*/
`timescale 1ns/1ps
`include "mrs_defs.svh"

module mrs_slave (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  slave_addr,
    input  wire logic        char_tick,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        tx_ready,
    output logic             tx_valid_r,
    output logic      [7:0]  tx_data_r,
    output logic             mem_rd_r,
    output logic             mem_wr_r,
    output logic      [15:0] mem_addr_r,
    output logic      [15:0] mem_wdata_r,
    input  wire logic [15:0] mem_rd_data,
    output logic             ack_manual_r,
    output logic             ack_event_r,
    output logic             ack_fault_r
);

    mrs_pkg::mrs_state_t st_r;
    mrs_pkg::mrs_phase_t ph_r;
    logic [7:0]  frm_r [0:15];
    logic [4:0]  cnt_r;
    logic        ovf_r;
    logic [1:0]  sil_r;
    logic        open_r;
    logic        fr_end_r;
    logic        bcast_r;
    logic        exc_r;
    logic [7:0]  ecode_r;
    logic [7:0]  rlen_r;
    logic [7:0]  idx_r;
    logic [15:0] word_r;
    logic        word_ok_r;
    logic [6:0]  rd_idx_r;
    logic [1:0]  wr_idx_r;
    logic [15:0] crc_rx;
    logic [15:0] crc_tx;
    logic        rx_take;
    logic        tx_hs;
    logic [7:0]  fc;
    logic [15:0] a_start;
    logic [15:0] qty;
    logic [15:0] a_last;
    logic        good;
    logic [7:0]  ecode_c;
    logic [7:0]  body_c;
    logic        need_word;
    logic [15:0] wr_addr_c;
    logic [15:0] wr_data_c;
    logic [1:0]  nwr;

    assign fc      = frm_r[1];
    assign a_start = {frm_r[2], frm_r[3]};
    assign qty     = {frm_r[4], frm_r[5]};
    assign a_last  = a_start + qty - 16'h0001;
    assign rx_take = rx_valid && (st_r == mrs_pkg::S_IDLE)
                     && (sil_r == `MRS_SIL_CHARS || open_r);
    assign tx_hs   = tx_valid_r && tx_ready;
    assign nwr     = (fc == `MRS_FC_WR_MULTI) ? qty[1:0] : 2'h1;

    // Page in the upper byte, offset in the lower
    function automatic logic rd_ok(input logic [15:0] a);
        logic [7:0] p;
        logic [7:0] o;
        p = a[15:8];
        o = a[7:0];
        if (p <= `MRS_PG_PAR_LAST)
            rd_ok = 1'b1;
        else if (p >= `MRS_PG_DIST_LO && p <= `MRS_PG_DIST_HI)
            rd_ok = (o <= `MRS_OFS_DIST_MAX);
        else if (p == `MRS_PG_DIST_IDX)
            rd_ok = 1'b1;
        else if (p == `MRS_PG_EVT)
            rd_ok = (o <= `MRS_OFS_EVT_MAX);
        else if (p == `MRS_PG_EVT_OLD)
            rd_ok = 1'b1;
        else if (p == `MRS_PG_FLT)
            rd_ok = (o <= `MRS_OFS_FLT_MAX);
        else if (p >= `MRS_PG_SEL_LO && p <= `MRS_PG_FLT_OLD)
            rd_ok = 1'b1;
        else
            rd_ok = 1'b0;
    endfunction

    function automatic logic wr_ok(input logic [15:0] a);
        logic [7:0] p;
        p = a[15:8];
        if (p >= 8'h01 && p <= `MRS_PG_PAR_LAST)
            wr_ok = 1'b1;
        else if (p == `MRS_PG_TSYNC)
            wr_ok = 1'b1;
        else if (p >= `MRS_PG_SEL_LO && p <= `MRS_PG_SEL_HI)
            wr_ok = 1'b1;
        else
            wr_ok = 1'b0;
    endfunction

    mrs_crc16 u_crc_rx (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (rx_take),
        .start (sil_r == `MRS_SIL_CHARS),
        .din   (rx_data),
        .crc_r (crc_rx)
    );

    mrs_crc16 u_crc_tx (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (tx_hs && ph_r == mrs_pkg::PH_BODY),
        .start (idx_r == 8'h00),
        .din   (tx_data_r),
        .crc_r (crc_tx)
    );

    // Frame gathering; bytes that arrive mid-reply or mid-gap are dropped
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_r    <= 5'h00;
            ovf_r    <= 1'b0;
            sil_r    <= `MRS_SIL_CHARS;
            open_r   <= 1'b0;
            fr_end_r <= 1'b0;
        end
        else
        begin
            fr_end_r <= 1'b0;
            if (rx_valid)
            begin
                sil_r <= 2'h0;
                if (rx_take && sil_r == `MRS_SIL_CHARS)
                begin
                    frm_r[0] <= rx_data;
                    cnt_r    <= 5'h01;
                    ovf_r    <= 1'b0;
                    open_r   <= 1'b1;
                end
                else if (rx_take && cnt_r == `MRS_BUF_BYTES)
                    ovf_r <= 1'b1;
                else if (rx_take)
                begin
                    frm_r[cnt_r[3:0]] <= rx_data;
                    cnt_r             <= cnt_r + 5'h01;
                end
            end
            else if (char_tick && sil_r != `MRS_SIL_CHARS)
            begin
                sil_r <= sil_r + 2'h1;
                if (sil_r == 2'h2 && open_r)
                begin
                    open_r   <= 1'b0;
                    fr_end_r <= 1'b1;
                end
            end
        end
    end

    assign good = !ovf_r && cnt_r >= 5'h04 && crc_rx == 16'h0000
                  && (frm_r[0] == `MRS_ADDR_BCAST
                      || (frm_r[0] == slave_addr
                          && slave_addr != `MRS_ADDR_BCAST
                          && slave_addr <= `MRS_ADDR_MAX));

    always_comb
    begin
        ecode_c = 8'h00;
        if (fc == `MRS_FC_RD_HOLD || fc == `MRS_FC_RD_INPUT)
        begin
            if (cnt_r != `MRS_LEN_FIXED || qty == 16'h0000
                || qty > `MRS_RD_MAX || !rd_ok(a_start) || !rd_ok(a_last)
                || a_start[15:8] != a_last[15:8])
                ecode_c = `MRS_EXC_DATA;
        end
        else if (fc == `MRS_FC_WR_BIT)
        begin
            if (cnt_r != `MRS_LEN_FIXED || !wr_ok(a_start)
                || (qty != `MRS_COIL_ON && qty != `MRS_COIL_OFF))
                ecode_c = `MRS_EXC_DATA;
        end
        else if (fc == `MRS_FC_WR_WORD)
        begin
            if (cnt_r != `MRS_LEN_FIXED || !wr_ok(a_start))
                ecode_c = `MRS_EXC_DATA;
        end
        else if (fc == `MRS_FC_QUICK)
        begin
            if (cnt_r != `MRS_LEN_QUICK)
                ecode_c = `MRS_EXC_DATA;
        end
        else if (fc == `MRS_FC_WR_MULTI)
        begin
            // Multi-word writes are held in the frame buffer, so capped
            if (qty == 16'h0000 || qty > `MRS_WR_MAX
                || frm_r[6] != {qty[6:0], 1'b0}
                || cnt_r != `MRS_LEN_MULTI0 + {qty[3:0], 1'b0}
                || !wr_ok(a_start) || !wr_ok(a_last)
                || a_start[15:8] != a_last[15:8])
                ecode_c = `MRS_EXC_DATA;
        end
        else
            ecode_c = `MRS_EXC_FUNC;
    end

    assign need_word = ph_r == mrs_pkg::PH_BODY && !word_ok_r && !exc_r
                       && (((fc == `MRS_FC_RD_HOLD || fc == `MRS_FC_RD_INPUT)
                            && idx_r >= 8'h03)
                           || (fc == `MRS_FC_QUICK && idx_r == 8'h02));

    always_comb
    begin
        body_c = 8'h00;
        if (idx_r == 8'h00)
            body_c = slave_addr;
        else if (idx_r == 8'h01)
            body_c = exc_r ? (fc | `MRS_FC_EXC_BIT) : fc;
        else if (exc_r)
            body_c = ecode_r;
        else if (fc == `MRS_FC_QUICK)
            body_c = word_r[7:0];
        else if (fc == `MRS_FC_RD_HOLD || fc == `MRS_FC_RD_INPUT)
        begin
            if (idx_r == 8'h02)
                body_c = {qty[6:0], 1'b0};
            else
                body_c = idx_r[0] ? word_r[15:8] : word_r[7:0];
        end
        else
            body_c = frm_r[idx_r[3:0]];
    end

    // Sequencer and byte sender
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r       <= mrs_pkg::S_IDLE;
            ph_r       <= mrs_pkg::PH_BODY;
            tx_valid_r <= 1'b0;
            tx_data_r  <= 8'h00;
            bcast_r    <= 1'b0;
            exc_r      <= 1'b0;
            ecode_r    <= 8'h00;
            rlen_r     <= 8'h00;
            idx_r      <= 8'h00;
            word_r     <= 16'h0000;
            word_ok_r  <= 1'b0;
            rd_idx_r   <= 7'h00;
            wr_idx_r   <= 2'h0;
        end
        else
        begin
            case (st_r)
            mrs_pkg::S_IDLE:
                if (fr_end_r)
                    st_r <= mrs_pkg::S_EVAL;
            mrs_pkg::S_EVAL:
            begin
                bcast_r   <= frm_r[0] == `MRS_ADDR_BCAST;
                exc_r     <= ecode_c != 8'h00;
                ecode_r   <= ecode_c;
                idx_r     <= 8'h00;
                rd_idx_r  <= 7'h00;
                wr_idx_r  <= 2'h0;
                word_ok_r <= 1'b0;
                ph_r      <= mrs_pkg::PH_BODY;
                if (ecode_c != 8'h00)
                    rlen_r <= 8'h03;
                else if (fc == `MRS_FC_RD_HOLD || fc == `MRS_FC_RD_INPUT)
                    rlen_r <= 8'h03 + {qty[6:0], 1'b0};
                else if (fc == `MRS_FC_QUICK)
                    rlen_r <= 8'h03;
                else
                    rlen_r <= 8'h06;
                if (!good)
                    st_r <= mrs_pkg::S_IDLE;
                else if (ecode_c != 8'h00)
                    st_r <= (frm_r[0] == `MRS_ADDR_BCAST) ?
                            mrs_pkg::S_IDLE : mrs_pkg::S_TX;
                else if (fc == `MRS_FC_WR_BIT || fc == `MRS_FC_WR_WORD
                         || fc == `MRS_FC_WR_MULTI)
                    st_r <= mrs_pkg::S_WR;
                else
                    st_r <= (frm_r[0] == `MRS_ADDR_BCAST) ?
                            mrs_pkg::S_IDLE : mrs_pkg::S_TX;
            end
            mrs_pkg::S_WR:
            begin
                wr_idx_r <= wr_idx_r + 2'h1;
                if (wr_idx_r + 2'h1 == nwr)
                    st_r <= bcast_r ? mrs_pkg::S_IDLE : mrs_pkg::S_TX;
            end
            mrs_pkg::S_RD:
                st_r <= mrs_pkg::S_RDW;
            mrs_pkg::S_RDW:
                st_r <= mrs_pkg::S_CAP;
            mrs_pkg::S_CAP:
            begin
                word_r    <= mem_rd_data;
                word_ok_r <= 1'b1;
                rd_idx_r  <= rd_idx_r + 7'h01;
                st_r      <= mrs_pkg::S_TX;
            end
            mrs_pkg::S_TX:
                if (need_word)
                    st_r <= mrs_pkg::S_RD;
                else
                begin
                    tx_valid_r <= 1'b1;
                    if (ph_r == mrs_pkg::PH_BODY)
                        tx_data_r <= body_c;
                    else if (ph_r == mrs_pkg::PH_CRCL)
                        tx_data_r <= crc_tx[7:0];
                    else
                        tx_data_r <= crc_tx[15:8];
                    st_r <= mrs_pkg::S_TXW;
                end
            mrs_pkg::S_TXW:
                if (tx_ready)
                begin
                    tx_valid_r <= 1'b0;
                    st_r       <= mrs_pkg::S_TX;
                    if (ph_r == mrs_pkg::PH_BODY)
                    begin
                        idx_r <= idx_r + 8'h01;
                        // A word is spent once its low byte has gone out
                        if (idx_r >= 8'h02 && !idx_r[0])
                            word_ok_r <= 1'b0;
                        if (idx_r + 8'h01 == rlen_r)
                            ph_r <= mrs_pkg::PH_CRCL;
                    end
                    else if (ph_r == mrs_pkg::PH_CRCL)
                        ph_r <= mrs_pkg::PH_CRCH;
                    else
                        st_r <= mrs_pkg::S_DONE;
                end
            mrs_pkg::S_DONE:
                st_r <= mrs_pkg::S_IDLE;
            default:
                st_r <= mrs_pkg::S_IDLE;
            endcase
        end
    end

    assign wr_addr_c = a_start + {14'h0000, wr_idx_r};
    assign wr_data_c = (fc != `MRS_FC_WR_MULTI) ? qty
                     : wr_idx_r[0] ? {frm_r[9], frm_r[10]}
                     : {frm_r[7], frm_r[8]};

    // Word store port; a read at S_RD is answered in S_CAP
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mem_rd_r    <= 1'b0;
            mem_wr_r    <= 1'b0;
            mem_addr_r  <= 16'h0000;
            mem_wdata_r <= 16'h0000;
        end
        else
        begin
            mem_rd_r <= st_r == mrs_pkg::S_RD;
            mem_wr_r <= st_r == mrs_pkg::S_WR;
            if (st_r == mrs_pkg::S_RD)
                mem_addr_r <= (fc == `MRS_FC_QUICK) ? `MRS_QUICK_ADDR
                              : a_start + {9'h000, rd_idx_r};
            else if (st_r == mrs_pkg::S_WR)
            begin
                mem_addr_r  <= wr_addr_c;
                mem_wdata_r <= wr_data_c;
            end
        end
    end

    // Record acknowledgement, automatic after a full reply or on command
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_manual_r <= 1'b0;
            ack_event_r  <= 1'b0;
            ack_fault_r  <= 1'b0;
        end
        else
        begin
            ack_event_r <= 1'b0;
            ack_fault_r <= 1'b0;
            if (st_r == mrs_pkg::S_WR && wr_addr_c == `MRS_CTRL_ADDR)
            begin
                ack_manual_r <= wr_data_c[`MRS_CTRL_MANUAL];
                ack_event_r  <= ack_manual_r
                                && wr_data_c[`MRS_CTRL_ACK_EVT];
                ack_fault_r  <= ack_manual_r
                                && wr_data_c[`MRS_CTRL_ACK_FLT];
            end
            else if (st_r == mrs_pkg::S_DONE && !exc_r && !ack_manual_r
                     && (fc == `MRS_FC_RD_HOLD || fc == `MRS_FC_RD_INPUT))
            begin
                ack_event_r <= a_start[15:8] == `MRS_PG_EVT_OLD;
                ack_fault_r <= a_start[15:8] == `MRS_PG_FLT_OLD;
            end
        end
    end

    no_bcast_reply_a: assert property (@(posedge clk) disable iff (!rst_n)
        bcast_r && st_r != mrs_pkg::S_EVAL |-> !tx_valid_r)
        else $error("Reply sent to broadcast");
    bad_crc_silent_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r == mrs_pkg::S_EVAL && crc_rx != 16'h0000
        |=> st_r == mrs_pkg::S_IDLE ##1 !tx_valid_r)
        else $error("Bad CRC frame answered");
    exc_func_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
        tx_valid_r && exc_r && ph_r == mrs_pkg::PH_BODY && idx_r == 8'h01
        |-> tx_data_r == (fc | `MRS_FC_EXC_BIT))
        else $error("Exception function byte wrong");
    exc_code_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        exc_r |-> ecode_r == `MRS_EXC_FUNC || ecode_r == `MRS_EXC_DATA)
        else $error("Unexpected exception code");
    page0_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r == mrs_pkg::S_EVAL && good && fc == `MRS_FC_WR_WORD
        && a_start[15:8] == `MRS_PG_INFO |=> exc_r && ecode_r == `MRS_EXC_DATA)
        else $error("Write to page 0 accepted");
    page7_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r == mrs_pkg::S_EVAL && good && fc == `MRS_FC_RD_HOLD
        && a_start[15:8] == 8'h07 |=> exc_r)
        else $error("Plain read of page 7 accepted");
    reply_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        tx_valid_r && ph_r == mrs_pkg::PH_BODY && idx_r == 8'h00
        |-> tx_data_r == slave_addr)
        else $error("Reply address differs");
    crc_low_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        tx_valid_r && ph_r == mrs_pkg::PH_CRCL && tx_ready
        |-> tx_data_r == crc_tx[7:0] ##2 tx_data_r == crc_tx[15:8])
        else $error("CRC byte order wrong");
    auto_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r == mrs_pkg::S_DONE && !exc_r && !ack_manual_r
        && fc == `MRS_FC_RD_HOLD && a_start[15:8] == `MRS_PG_EVT_OLD
        |=> ack_event_r && !ack_fault_r)
        else $error("Oldest event not acknowledged");
    frame_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        fr_end_r |-> sil_r == `MRS_SIL_CHARS && $past(char_tick))
        else $error("Frame ended without full gap");

endmodule

// *** mrs_master_model.sv ***
/*
 Bus master model: sends a query a byte per character time, CRC last,
 and gathers the reply. Assumes the slave's byte-level link ports.
*/
`timescale 1ns/1ps
module mrs_master_model (
    input  wire logic       clk,
    output logic            char_tick,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            tx_ready,
    input  wire logic       tx_valid_r,
    input  wire logic [7:0] tx_data_r
);
    logic [2:0] div = 3'h0;
    logic       slow = 1'b0;
    logic [7:0] got[$];
    initial
    begin
        char_tick = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end
    // Line time runs on; one tick every eight clocks
    always @(negedge clk)
    begin
        div <= div + 3'h1;
        char_tick <= (div == 3'h7);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    always @(posedge clk)
        if (tx_valid_r && tx_ready)
            got.push_back(tx_data_r);
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i])
        begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction
    task automatic send(input logic [7:0] q[$], input logic bad);
        logic [15:0] c;
        c = crc(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        got.delete();
        foreach (q[i])
        begin
            @(negedge clk);
            rx_valid <= 1'b1;
            rx_data <= q[i];
            @(negedge clk);
            rx_valid <= 1'b0;
            // Inverted so a stale byte is never mistaken for a new one
            rx_data <= ~q[i];
            repeat (6) @(negedge clk);
        end
    endtask
endmodule

// *** mrs_slave_tb.sv ***
/*
 Testbench of the bus slave: master model on the link, word store that
 answers with its offset byte, then that byte xor 5ah, so a word fetched
 from the wrong offset shows. Assumes own address 11h.
*/
`timescale 1ns/1ps
module mrs_slave_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        char_tick, rx_valid, tx_ready, tx_valid_r, mem_rd_r;
    logic        mem_wr_r, ack_manual_r, ack_event_r, ack_fault_r;
    logic [7:0]  rx_data, tx_data_r;
    logic [15:0] mem_addr_r, mem_wdata_r, mem_rd_data;
    int          miscompares = 0, total_checks = 0, cycles = 0;
    int          n_wr = 0, n_ev = 0, n_ft = 0, n_rd = 0;
    mrs_slave DUT (.clk(clk), .rst_n(rst_n), .slave_addr(8'h11),
        .char_tick(char_tick), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_ready(tx_ready), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r),
        .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r), .mem_addr_r(mem_addr_r),
        .mem_wdata_r(mem_wdata_r), .mem_rd_data(mem_rd_data),
        .ack_manual_r(ack_manual_r), .ack_event_r(ack_event_r),
        .ack_fault_r(ack_fault_r));
    mrs_master_model M (.clk(clk), .char_tick(char_tick),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
        .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r));
    assign mem_rd_data = {mem_addr_r[7:0], mem_addr_r[7:0] ^ 8'h5a};
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        n_wr += (mem_wr_r === 1'b1);
        n_rd += (mem_rd_r === 1'b1);
        n_ev += (ack_event_r === 1'b1);
        n_ft += (ack_fault_r === 1'b1);
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task print_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    // Queries are six bytes; expected reply bytes sit left-aligned in e
    task automatic xact(input logic [47:0] q, input logic bad,
              input logic [47:0] e,
              input int n);
        logic [7:0]  qq[$];
        logic [7:0]  ee[$];
        logic [15:0] c;
        for (int i = 5; i >= 0; i--)
            qq.push_back(q[i*8 +: 8]);
        for (int i = 5; i > 5 - n; i--)
            ee.push_back(e[i*8 +: 8]);
        c = M.crc(ee);
        if (n > 0)
        begin
            ee.push_back(c[7:0]);
            ee.push_back(c[15:8]);
        end
        M.send(qq, bad);
        repeat (200) @(negedge clk);
        chk(M.got.size() == ee.size(), "reply length");
        foreach (ee[i])
            chk(M.got[i] === ee[i], "reply byte");
    endtask
    task t_write();
        int w;
        w = n_wr;
        xact(48'h110601000005, 0, 48'h110601000005, 6);
        chk(n_wr == w + 1 && mem_addr_r === 16'h0100, "write addr");
        chk(mem_wdata_r === 16'h0005, "write data");
        xact(48'h110608000001, 0, 48'h110608000001, 6);
        xact(48'h110601000005, 1, 0, 0);
        xact(48'h120601000005, 0, 0, 0);
        xact(48'h000601000007, 0, 0, 0);
        chk(n_wr == w + 3 && mem_wdata_r === 16'h0007, "broadcast");
        xact(48'h11050200ff00, 0, 48'h11050200ff00, 6);
        chk(mem_wdata_r === 16'hff00, "bit write");
    endtask
    task t_exc();
        xact(48'h110600000001, 0, 48'h118603000000, 3);
        xact(48'h110100000001, 0, 48'h118101000000, 3);
        xact(48'h110307000001, 0, 48'h118303000000, 3);
        xact(48'h110305000001, 0, 48'h118303000000, 3);
        xact(48'h110309fb0001, 0, 48'h118303000000, 3);
        xact(48'h110309fa0001, 0, 48'h110302faa000, 5);
        xact(48'h110422000001, 0, 48'h110402005a00, 5);
        xact(48'h110502000001, 0, 48'h118503000000, 3);
        xact(48'h110335640001, 0, 48'h118303000000, 3);
        xact(48'h110300000001, 0, 48'h110302005a00, 5);
    endtask
    task t_ack();
        int e, f;
        e = n_ev;
        f = n_ft;
        xact(48'h110604001000, 0, 48'h110604001000, 6);
        chk(ack_manual_r === 1'b1, "manual mode");
        xact(48'h110336000001, 0, 48'h110302005a00, 5);
        xact(48'h110604007000, 0, 48'h110604007000, 6);
        chk(n_ev == e + 1 && n_ft == f + 1, "manual ack");
        xact(48'h110604000000, 0, 48'h110604000000, 6);
        M.slow = 1'b1;
        xact(48'h11033e000001, 0, 48'h110302005a00, 5);
        M.slow = 1'b0;
        chk(n_ev == e + 1 && n_ft == f + 2, "auto ack");
        chk(ack_manual_r === 1'b0, "auto mode");
        xact(48'h110336000001, 0, 48'h110302005a00, 5);
        chk(n_ev == e + 2 && n_ft == f + 2, "auto event ack");
    endtask
    task automatic t_long();
        logic [7:0] q[$];
        int r;
        r = n_rd;
        q = '{8'h11, 8'h07};
        M.send(q, 0);
        repeat (200) @(negedge clk);
        chk(M.got.size() == 5 && M.got[2] === 8'h5a, "quick");
        chk(n_rd == r + 1 && mem_addr_r === 16'h0700, "quick addr");
        q = '{8'h11, 8'h10, 8'h01, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
        M.send(q, 0);
        repeat (200) @(negedge clk);
        chk(M.got.size() == 8 && mem_wdata_r === 16'h1234, "multi");
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        t_write();
        t_exc();
        t_ack();
        t_long();
        print_verdict();
    end
endmodule
